// >>> rtl/frl_pkg.sv
// constants and types shared by the flash region lock and fuse protection block
package frl_pkg;
    // register byte offsets
    localparam logic [7:0] FRL_CTRL_OFS = 8'h00;
    localparam logic [7:0] FRL_CMD_OFS = 8'h04;
    localparam logic [7:0] FRL_STAT_OFS = 8'h08;
    localparam logic [7:0] FRL_FUSE_HI_OFS = 8'h14;
    localparam logic [7:0] FRL_FUSE_LO_OFS = 8'h18;
    // command register fields
    localparam logic [7:0] FRL_KEY = 8'ha5;
    localparam int FRL_KEY_LSB = 24;
    localparam int FRL_PAGE_LSB = 8;
    localparam int FRL_CMD_W = 6;
    // status register bit positions
    localparam int FRL_ST_RDY = 0;
    localparam int FRL_ST_LOCK_ERR = 2;
    localparam int FRL_ST_PROGE = 3;
    localparam int FRL_ST_SEC = 4;
    localparam int FRL_ST_LOCK_LSB = 16;
    // fuse layout
    localparam int FRL_FUSE_W = 32;
    localparam int FRL_NREG = 16;
    localparam int FRL_FETCH_LOCK_BIT = 16;
    localparam int FRL_BOOT_LSB = 17;
    localparam int FRL_SEC_LSB = 20;
    localparam int FRL_USER_PROT_BIT = 22;
    localparam logic [2:0] FRL_BOOT_NONE = 3'h7;
    localparam logic [31:0] FRL_FUSE_ERASED = 32'hffffffff;
    localparam logic [1:0] FRL_BYTE2 = 2'h2;
    // fuse bits guarded by the security bit: 22..16
    localparam logic [31:0] FRL_SEC_GUARD = 32'h007f0000;
    localparam logic [31:0] FRL_SECURE_MASK = 32'h00300000;
    // flash operation duration in cycles
    localparam logic [3:0] FRL_OP_CYC = 4'h8;

    typedef enum logic [5:0] {
        FRL_C_NOP = 6'h00,
        FRL_C_WP = 6'h01,
        FRL_C_EP = 6'h02,
        FRL_C_EA = 6'h05,
        FRL_C_LOCK = 6'h08,
        FRL_C_UNLOCK = 6'h09,
        FRL_C_WGPB = 6'h0a,
        FRL_C_EGPB = 6'h0b,
        FRL_C_SSB = 6'h0c,
        FRL_C_PGPFB = 6'h0d,
        FRL_C_EAGP = 6'h0e
    } frl_cmd_t;

    typedef enum logic [1:0] {
        FRL_S_IDLE = 2'b00,
        FRL_S_BUSY = 2'b01,
        FRL_S_DONE = 2'b10
    } frl_state_t;
endpackage

// >>> rtl/frl_prot_check.sv
// page protection check against region locks and bootloader area
`timescale 1ns/1ps
`default_nettype none
module frl_prot_check #(
    parameter int PAGE_W = 10
) (
    input wire logic [PAGE_W-1:0] page,
    input wire logic [15:0] lock_fuses,
    input wire logic [2:0] boot_size,
    output logic page_blocked,
    output logic any_blocked
);
    import frl_pkg::*;
    logic [3:0] region;
    logic [PAGE_W:0] boot_pages;

    // region index is the top four page bits: p/16 pages each
    assign region = page[PAGE_W-1 -: 4];
    // size 7 gives 0 pages, 6 gives 2, each lower value doubles
    assign boot_pages = (boot_size == FRL_BOOT_NONE) ? '0 :
        (PAGE_W+1)'(2) << (3'(FRL_BOOT_NONE - 3'h1) - boot_size);
    assign page_blocked = !lock_fuses[region]
        || ({1'b0, page} < boot_pages);
    assign any_blocked = (lock_fuses != 16'hffff)
        || (boot_size != FRL_BOOT_NONE);
endmodule
`default_nettype wire

// >>> rtl/frl_top.sv
// flash region lock and fuse protection with axi4-lite register access
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module frl_top #(
    parameter int PAGE_W = 10,
    parameter logic [31:0] FUSE_INIT = frl_pkg::FRL_FUSE_ERASED
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] nv_fuse_in,
    input wire logic nv_security_in,
    output logic nv_fuse_we,
    output logic [31:0] nv_fuse_out,
    output logic nv_security_set,
    output logic flash_op_start,
    output logic flash_op_erase,
    output logic [PAGE_W-1:0] flash_op_page,
    output logic external_fetch_lock_fuse,
    output logic [2:0] bootloader_size_fuses,
    output logic secure_state_enable,
    output logic secure_debug_enable,
    output logic user_protection_fuse
);
    import frl_pkg::*;

    // ************************************************
    // state
    // ************************************************
    logic [31:0] fuse_r;
    logic security_r;
    logic load_pend_r;
    logic [31:0] ctrl_r;
    logic [31:0] cmd_r;
    logic lock_error_flag_r;
    logic proge_r;
    frl_state_t state_r;
    logic [3:0] cnt_r;
    logic [31:0] fuse_nxt;
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;

    // ************************************************
    // functions
    // ************************************************
    function automatic logic is_valid(input logic [5:0] c);
        unique case (c)
            FRL_C_NOP, FRL_C_WP, FRL_C_EP, FRL_C_EA, FRL_C_LOCK, FRL_C_UNLOCK,
            FRL_C_WGPB, FRL_C_EGPB, FRL_C_SSB, FRL_C_PGPFB, FRL_C_EAGP: is_valid = 1'b1;
            default: is_valid = 1'b0;
        endcase
    endfunction

    // true when a change from old to new fuse image is forbidden
    function automatic logic fuse_denied(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic sec);
        logic [31:0] diff;
        diff = old_v ^ new_v;
        fuse_denied = (sec && ((diff & FRL_SEC_GUARD) != '0))
            || ((diff & FRL_SECURE_MASK) != '0
                && (old_v[FRL_SEC_LSB +: 2] == 2'b01 || old_v[FRL_SEC_LSB +: 2] == 2'b10));
    endfunction

    // ************************************************
    // axi4-lite write channel
    // ************************************************
    logic wr_go;
    logic rd_go;
    logic cmd_wr;
    logic [31:0] wdata_eff;
    assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign cmd_wr = wr_go && aw_addr_r == FRL_CMD_OFS && w_strb_r == 4'hf;
    assign wdata_eff = w_data_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            aw_addr_r <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_hold_r && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (wr_go) begin
                aw_hold_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_hold_r && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (wr_go) begin
                w_hold_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_r == FRL_CTRL_OFS || aw_addr_r == FRL_CMD_OFS) ?
                2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= '0;
        end else if (wr_go && aw_addr_r == FRL_CTRL_OFS) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb_r[b]) begin
                    ctrl_r[b*8 +: 8] <= wdata_eff[b*8 +: 8];
                end
            end
        end
    end

    // ************************************************
    // command decode and protection
    // ************************************************
    logic [5:0] cmd_code;
    logic [PAGE_W-1:0] cmd_page;
    logic key_ok;
    logic page_blocked;
    logic any_blocked;
    assign cmd_code = cmd_r[FRL_CMD_W-1:0];
    assign cmd_page = cmd_r[FRL_PAGE_LSB +: PAGE_W];
    assign key_ok = wdata_eff[FRL_KEY_LSB +: 8] == FRL_KEY;

    frl_prot_check #(.PAGE_W(PAGE_W)) u_chk (
        .page(cmd_page),
        .lock_fuses(fuse_r[FRL_NREG-1:0]),
        .boot_size(fuse_r[FRL_BOOT_LSB +: 3]),
        .page_blocked(page_blocked),
        .any_blocked(any_blocked)
    );

    // fuse image a command would produce
    always_comb begin
        fuse_nxt = fuse_r;
        unique case (cmd_code)
            FRL_C_LOCK: fuse_nxt[cmd_page[PAGE_W-1 -: 4]] = 1'b0;
            FRL_C_UNLOCK: fuse_nxt[cmd_page[PAGE_W-1 -: 4]] = 1'b1;
            FRL_C_WGPB: fuse_nxt[cmd_r[FRL_PAGE_LSB +: 5]] = 1'b0;
            FRL_C_EGPB: fuse_nxt[cmd_r[FRL_PAGE_LSB +: 5]] = 1'b1;
            FRL_C_PGPFB: fuse_nxt[cmd_r[FRL_PAGE_LSB +: 2]*8 +: 8] =
                cmd_r[FRL_PAGE_LSB+3 +: 8];
            FRL_C_EAGP: fuse_nxt = FRL_FUSE_ERASED;
            default: fuse_nxt = fuse_r;
        endcase
    end

    logic is_fuse_cmd;
    logic is_flash_cmd;
    logic cmd_blocked;
    assign is_fuse_cmd = cmd_code == FRL_C_LOCK || cmd_code == FRL_C_UNLOCK
        || cmd_code == FRL_C_WGPB || cmd_code == FRL_C_EGPB
        || cmd_code == FRL_C_PGPFB || cmd_code == FRL_C_EAGP;
    assign is_flash_cmd = cmd_code == FRL_C_WP || cmd_code == FRL_C_EP
        || cmd_code == FRL_C_EA;
    always_comb begin
        cmd_blocked = 1'b0;
        if (cmd_code == FRL_C_EA) begin
            cmd_blocked = any_blocked;
        end else if (cmd_code == FRL_C_WP || cmd_code == FRL_C_EP) begin
            cmd_blocked = page_blocked;
        end else if (is_fuse_cmd) begin
            cmd_blocked = fuse_denied(fuse_r, fuse_nxt, security_r)
                || (security_r && cmd_code == FRL_C_EAGP)
                || (security_r && cmd_code == FRL_C_PGPFB
                    && cmd_r[FRL_PAGE_LSB +: 2] == FRL_BYTE2);
        end
    end

    // ************************************************
    // command sequencer
    // ************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_r <= '0;
            state_r <= FRL_S_DONE;
            cnt_r <= '0;
        end else begin
            unique case (state_r)
                FRL_S_IDLE: begin
                    if (cmd_wr && key_ok && is_valid(wdata_eff[FRL_CMD_W-1:0])) begin
                        cmd_r <= {8'h00, wdata_eff[23:0]};
                        state_r <= FRL_S_BUSY;
                        cnt_r <= FRL_OP_CYC;
                    end
                end
                FRL_S_BUSY: begin
                    if (cnt_r == 4'h0 || !is_flash_cmd || cmd_blocked) begin
                        state_r <= FRL_S_DONE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                FRL_S_DONE: begin
                    if (!load_pend_r) begin
                        state_r <= FRL_S_IDLE;
                    end
                end
                default: state_r <= FRL_S_IDLE;
            endcase
        end
    end

    logic first_busy;
    assign first_busy = state_r == FRL_S_BUSY && cnt_r == FRL_OP_CYC;

    // flash operation start pulse only for unprotected page commands and erase-all
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flash_op_start <= 1'b0;
            flash_op_erase <= 1'b0;
            flash_op_page <= '0;
        end else begin
            flash_op_start <= first_busy && is_flash_cmd && !cmd_blocked;
            flash_op_erase <= cmd_code != FRL_C_WP;
            flash_op_page <= cmd_page;
        end
    end

    // ************************************************
    // fuse image and nonvolatile write-back
    // ************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fuse_r <= FUSE_INIT;
            security_r <= 1'b0;
            load_pend_r <= 1'b1;
            nv_fuse_we <= 1'b0;
            nv_fuse_out <= '0;
            nv_security_set <= 1'b0;
        end else begin
            nv_fuse_we <= 1'b0;
            nv_security_set <= 1'b0;
            if (load_pend_r) begin
                // strap-like capture after release of reset
                fuse_r <= nv_fuse_in;
                security_r <= nv_security_in;
                load_pend_r <= 1'b0;
            end else if (first_busy && is_fuse_cmd && !cmd_blocked) begin
                fuse_r <= fuse_nxt;
                nv_fuse_we <= 1'b1;
                nv_fuse_out <= fuse_nxt;
            end else if (first_busy && cmd_code == FRL_C_SSB) begin
                security_r <= 1'b1;
                nv_security_set <= 1'b1;
            end
        end
    end

    // ************************************************
    // status flags: set wins over read-clear
    // ************************************************
    logic stat_rd;
    assign stat_rd = rd_go && s_axi_araddr == FRL_STAT_OFS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            proge_r <= 1'b0;
        end else if (cmd_wr && (!key_ok || !is_valid(wdata_eff[FRL_CMD_W-1:0])
                                || state_r != FRL_S_IDLE)) begin
            proge_r <= 1'b1;
        end else if (stat_rd) begin
            proge_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_error_flag_r <= 1'b0;
        end else if (first_busy && cmd_blocked) begin
            lock_error_flag_r <= 1'b1;
        end else if (stat_rd) begin
            lock_error_flag_r <= 1'b0;
        end
    end

    // ************************************************
    // axi4-lite read channel
    // ************************************************
    assign rd_go = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !rd_go;
            if (rd_go) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                unique case (s_axi_araddr)
                    FRL_CTRL_OFS: s_axi_rdata <= ctrl_r;
                    FRL_CMD_OFS: s_axi_rdata <= {8'h00, cmd_r[23:0]};
                    FRL_STAT_OFS: begin
                        s_axi_rdata <= '0;
                        s_axi_rdata[FRL_ST_RDY] <= state_r == FRL_S_IDLE;
                        s_axi_rdata[FRL_ST_LOCK_ERR] <= lock_error_flag_r;
                        s_axi_rdata[FRL_ST_PROGE] <= proge_r;
                        s_axi_rdata[FRL_ST_SEC] <= security_r;
                        s_axi_rdata[FRL_ST_LOCK_LSB +: FRL_NREG] <= ~fuse_r[FRL_NREG-1:0];
                    end
                    FRL_FUSE_HI_OFS: s_axi_rdata <= '0;
                    FRL_FUSE_LO_OFS: s_axi_rdata <= fuse_r;
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ************************************************
    // fuse-driven outputs
    // ************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            external_fetch_lock_fuse <= 1'b1;
            bootloader_size_fuses <= FRL_BOOT_NONE;
            secure_state_enable <= 1'b0;
            secure_debug_enable <= 1'b0;
            user_protection_fuse <= 1'b1;
        end else begin
            external_fetch_lock_fuse <= fuse_r[FRL_FETCH_LOCK_BIT];
            bootloader_size_fuses <= fuse_r[FRL_BOOT_LSB +: 3];
            secure_state_enable <= fuse_r[FRL_SEC_LSB] ^ fuse_r[FRL_SEC_LSB+1];
            secure_debug_enable <= fuse_r[FRL_SEC_LSB +: 2] == 2'b01;
            user_protection_fuse <= fuse_r[FRL_USER_PROT_BIT];
        end
    end
endmodule
`default_nettype wire

// >>> tb/frl_chk.sv
// assertion checker for the flash region lock block, bound to frl_top
`timescale 1ns/1ps
`default_nettype none
module frl_top_chk #(
    parameter int PAGE_W = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic nv_fuse_we,
    input wire logic flash_op_start,
    input wire logic [PAGE_W-1:0] flash_op_page,
    input wire logic external_fetch_lock_fuse,
    input wire logic [2:0] bootloader_size_fuses,
    input wire logic secure_state_enable,
    input wire logic secure_debug_enable,
    input wire logic user_protection_fuse
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ************************************************
    // settle counter: fuse outputs load freely just after reset
    // ************************************************
    logic [2:0] up_cnt_r;
    always_ff @(posedge aclk) begin
        if (!aresetn)
            up_cnt_r <= 3'h0;
        else if (up_cnt_r != 3'h7)
            up_cnt_r <= up_cnt_r + 3'h1;
    end
    AST_B_AFTER_W: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped early");
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address accepted while response pending");
    AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read data missing");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped early");
    AST_R_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == 2'b10
        |-> s_axi_rdata == 32'h0) else $error("error read returned data");
    AST_SEC_DECODE: assert property (secure_debug_enable |-> secure_state_enable)
        else $error("secure debug without secure state");
    AST_OP_SPACING: assert property (flash_op_start |=> !flash_op_start [*8])
        else $error("flash operation restarted while busy");
    AST_BOOT_GUARD: assert property (flash_op_start && bootloader_size_fuses != 3'h7
        |-> int'(flash_op_page) >= (2 << (6 - int'(bootloader_size_fuses))))
        else $error("flash operation inside bootloader area");
    AST_FUSE_PULSE: assert property (nv_fuse_we |=> !nv_fuse_we)
        else $error("fuse write strobe longer than one cycle");
    AST_FUSE_STABLE: assert property (up_cnt_r >= 3'h4 && $changed({external_fetch_lock_fuse,
        bootloader_size_fuses, user_protection_fuse}) |-> nv_fuse_we || $past(nv_fuse_we)
        || $past(nv_fuse_we, 2)) else $error("fuse output changed without fuse command");
endmodule
bind frl_top frl_top_chk #(.PAGE_W(PAGE_W)) u_frl_top_chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .nv_fuse_we, .flash_op_start, .flash_op_page, .external_fetch_lock_fuse,
    .bootloader_size_fuses, .secure_state_enable, .secure_debug_enable, .user_protection_fuse);
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking testbench for the flash region lock and fuse protection block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import frl_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic nv_security_in = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, nv_fuse_in = 32'hffebfff7, s_axi_rdata, nv_fuse_out;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_rvalid, nv_fuse_we, nv_security_set, flash_op_start, flash_op_erase;
    logic [9:0] flash_op_page, last_page;
    logic external_fetch_lock_fuse, secure_state_enable, secure_debug_enable;
    logic user_protection_fuse, last_erase;
    logic [2:0] bootloader_size_fuses;
    // model fuse image: boot size 5, secure 10, region 3 locked
    logic [31:0] f = 32'hffebfff7, nv_img, v;
    logic [1:0] r;
    int n_tests = 0, n_mismatch = 0, n_start = 0, n_ssb = 0, j, pg, op, ex;
    int dir[4] = '{192, 3, 4, 255};
    integer seed = 32'hc3cc27b1;
    always #2 aclk = ~aclk;
    frl_top #(.PAGE_W(10)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nv_fuse_in, .nv_security_in, .nv_fuse_we,
        .nv_fuse_out, .nv_security_set, .flash_op_start, .flash_op_erase, .flash_op_page,
        .external_fetch_lock_fuse, .bootloader_size_fuses, .secure_state_enable,
        .secure_debug_enable, .user_protection_fuse);
    always @(posedge aclk) begin
        if (flash_op_start === 1'b1) begin
            n_start <= n_start + 1;
            last_page <= flash_op_page;
            last_erase <= flash_op_erase;
        end
        if (nv_fuse_we === 1'b1)
            nv_img <= nv_fuse_out;
        if (nv_security_set === 1'b1)
            n_ssb <= n_ssb + 1;
    end
    // ************************************************
    // checking, bus tasks and model
    // ************************************************
    task wrap_up;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        int i;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 64 && !s_axi_bvalid; i++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (i == 64)
            chk(0, 1);
        if (i == 64)
            wrap_up();
        @(posedge aclk);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 64 && !s_axi_rvalid; i++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (i == 64)
            chk(0, 1);
        if (i == 64)
            wrap_up();
        @(posedge aclk);
    endtask
    // one command, then status after the longest busy time plus ready delay
    task cmd(input logic [7:0] k, input logic [5:0] c, input int p, input int st,
        input logic le, input logic pe);
        int n0;
        n0 = n_start;
        wr(FRL_CMD_OFS, {k, p[15:0], 2'h0, c}, r);
        repeat (16) @(posedge aclk);
        rd(FRL_STAT_OFS, v, r);
        chk(n_start - n0, st);
        chk(v[FRL_ST_LOCK_ERR], le);
        chk(v[FRL_ST_PROGE], pe);
    endtask
    task fchk;
        chk(external_fetch_lock_fuse, f[16]);
        chk(bootloader_size_fuses, f[19:17]);
        chk(secure_state_enable, f[21:20] == 2'h1 || f[21:20] == 2'h2);
        chk(secure_debug_enable, f[21:20] == 2'h1);
        chk(user_protection_fuse, f[22]);
        rd(FRL_FUSE_LO_OFS, v, r);
        chk(v, f);
        rd(FRL_STAT_OFS, v, r);
        chk(v[31:16], {16'h0, ~f[15:0]});
    endtask
    function automatic bit blk(input int p);
        int b;
        b = f[19:17];
        return !f[p >> 6] || (b != 7 && p < (2 << (6 - b)));
    endfunction
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        fchk();
        $display("test reset load done");
        ex = $random(seed);
        wr(FRL_CTRL_OFS, ex, r);
        rd(FRL_CTRL_OFS, v, r);
        chk(v, ex);
        wr(FRL_STAT_OFS, 32'h0, r);
        chk(r, 2'b10);
        rd(8'h40, v, r);
        chk(r, 2'b10);
        chk(v, 32'h0);
        $display("test register bus done");
        for (j = 0; j < 16; j++) begin
            pg = (j < 4) ? dir[j] : ($random(seed) & 32'h3ff);
            op = $random(seed) & 1;
            ex = !blk(pg);
            cmd(FRL_KEY, op ? FRL_C_EP : FRL_C_WP, pg, ex, !ex, 1'b0);
            if (ex)
                chk({last_erase, last_page}, {op[0], pg[9:0]});
        end
        $display("test page protection done");
        cmd(8'h5a, FRL_C_WP, 500, 0, 1'b0, 1'b1);
        cmd(FRL_KEY, 6'h3f, 500, 0, 1'b0, 1'b1);
        wr(FRL_CMD_OFS, {FRL_KEY, 16'd500, 2'h0, FRL_C_WP}, r);
        cmd(FRL_KEY, FRL_C_WP, 501, 1, 1'b0, 1'b1);
        cmd(FRL_KEY, FRL_C_EA, 0, 0, 1'b1, 1'b0);
        $display("test command errors done");
        cmd(FRL_KEY, FRL_C_UNLOCK, 200, 0, 1'b0, 1'b0);
        f[3] = 1'b1;
        cmd(FRL_KEY, FRL_C_LOCK, 1023, 0, 1'b0, 1'b0);
        f[15] = 1'b0;
        cmd(FRL_KEY, FRL_C_WGPB, 16, 0, 1'b0, 1'b0);
        f[16] = 1'b0;
        chk(nv_img, f);
        fchk();
        cmd(FRL_KEY, FRL_C_EGPB, 16, 0, 1'b0, 1'b0);
        f[16] = 1'b1;
        cmd(FRL_KEY, FRL_C_WGPB, 21, 0, 1'b1, 1'b0);
        cmd(FRL_KEY, FRL_C_WP, 1000, 0, 1'b1, 1'b0);
        cmd(FRL_KEY, FRL_C_SSB, 0, 0, 1'b0, 1'b0);
        chk(v[FRL_ST_SEC], 1'b1);
        chk(n_ssb, 1);
        fchk();
        $display("test lock commands done");
        aresetn <= 1'b0;
        nv_fuse_in <= f;
        nv_security_in <= 1'b1;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        cmd(FRL_KEY, FRL_C_WGPB, 17, 0, 1'b1, 1'b0);
        cmd(FRL_KEY, FRL_C_WGPB, 16, 0, 1'b1, 1'b0);
        cmd(FRL_KEY, FRL_C_WGPB, 22, 0, 1'b1, 1'b0);
        cmd(FRL_KEY, FRL_C_EAGP, 0, 0, 1'b1, 1'b0);
        chk(v[FRL_ST_SEC], 1'b1);
        fchk();
        $display("test security done");
        wrap_up();
    end
endmodule
`default_nettype wire
